/* File: hdl/macdc_pkg.sv */
// constants, layouts and types for the duplex, collision and jamming mac block
// ============================================================================
package macdc_pkg;

    // ========================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned BIT_TIME_NS = 100;
    localparam int unsigned BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BYTE_CYC = 8 * BIT_CYC;
    localparam int unsigned SLOT_BITS = 512;
    localparam int unsigned SLOT_CYC = SLOT_BITS * BIT_CYC;

    // ========================================================================
    // frame and retry figures
    localparam logic [10:0] LATE_COL_BYTES = 11'h040;
    localparam logic [3:0] MAX_RETRIES = 4'hF;
    localparam logic [3:0] BACKOFF_CAP = 4'hA;
    localparam logic [10:0] SFD_INDEX = 11'h007;
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [15:0] LFSR_SEED = 16'h0001;

    // ========================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_MAC_ONE = 8'h18;
    localparam logic [7:0] OFS_MAC_THREE = 8'h1C;
    localparam logic [7:0] OFS_PHY_ONE = 8'h20;
    localparam logic [7:0] OFS_FLOW = 8'h24;
    localparam logic [7:0] OFS_GAP = 8'h28;
    localparam logic [7:0] OFS_FRAME_LEN = 8'h2C;
    localparam logic [7:0] OFS_RETRY = 8'h30;

    // ========================================================================
    // field positions
    localparam int unsigned CTL1_TXREQ_BIT = 3;
    localparam int unsigned CTL1_RX_ENABLE_BIT = 2;
    localparam int unsigned CTL2_ENABLE_BIT = 5;
    localparam int unsigned MAC3_FDX_BIT = 0;
    localparam int unsigned PHY1_DPX_BIT = 8;
    localparam int unsigned FLOW_LOW_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_ABORT_BIT = 1;
    localparam int unsigned STAT_JAM_BIT = 2;
    localparam int unsigned STAT_MISMATCH_BIT = 3;
    localparam int unsigned IRQ_TXERR_BIT = 1;
    localparam int unsigned IRQ_RETRY_BIT = 2;
    localparam int unsigned IRQ_TXDONE_BIT = 3;

    // ========================================================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CTL_TWO = 8'h20;
    localparam logic [6:0] RST_GAP = 7'h00;
    localparam logic [10:0] RST_FRAME_LEN = 11'h040;

    // ========================================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE, ST_JAM, ST_DEFER, ST_GAP, ST_PREAMBLE, ST_DATA, ST_BACKOFF
    } macdc_state_t;

    typedef struct packed {
        logic en;
        logic [7:0] data;
    } macdc_line_t;

endpackage

/* File: hdl/macdc_top.sv */
// duplex select, deferral, collision retry and jamming transmit engine
`timescale 1ns/1ps
module macdc_top (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic crs_i,
    input wire logic col_i,
    input wire logic [7:0] frame_byte_i,
    output logic [10:0] frame_idx_o,
    output macdc_pkg::macdc_line_t tx_line_o,
    output logic rx_enable_o,
    output logic full_duplex_o,
    output logic irq_o
);
    import macdc_pkg::*;

    // ========================================================================
    // pin synchronisers
    logic [2:0] crs_sync_r;
    logic [2:0] col_sync_r;
    logic crs_r;
    logic col_r;

    // three stages; a level counts once the last two agree
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            crs_sync_r <= 3'h0;
            col_sync_r <= 3'h0;
            crs_r <= 1'b0;
            col_r <= 1'b0;
        end else begin
            crs_sync_r <= {crs_sync_r[1:0], crs_i};
            col_sync_r <= {col_sync_r[1:0], col_i};
            if (crs_sync_r[1] == crs_sync_r[2]) begin
                crs_r <= crs_sync_r[2];
            end
            if (col_sync_r[1] == col_sync_r[2]) begin
                col_r <= col_sync_r[2];
            end
        end
    end

    // ========================================================================
    // ahb-lite slave: zero wait, always okay
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;
    wire addr_ok = hsel_i & htrans_i[1] & hready_i;

    // address phase captured; read data registered for the data phase
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ok & hwrite_i;
            wr_addr_r <= haddr_i[7:0];
            hrdata_r <= (addr_ok & ~hwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;

    // write strobes, one per writable register
    wire wr_ctl1 = wr_pend_r && (wr_addr_r == OFS_CTL_ONE);
    wire wr_ctl2 = wr_pend_r && (wr_addr_r == OFS_CTL_TWO);
    wire wr_ien = wr_pend_r && (wr_addr_r == OFS_IRQ_EN);
    wire wr_iclr = wr_pend_r && (wr_addr_r == OFS_IRQ_CLR);
    wire wr_mac1 = wr_pend_r && (wr_addr_r == OFS_MAC_ONE);
    wire wr_mac3 = wr_pend_r && (wr_addr_r == OFS_MAC_THREE);
    wire wr_phy1 = wr_pend_r && (wr_addr_r == OFS_PHY_ONE);
    wire wr_flow = wr_pend_r && (wr_addr_r == OFS_FLOW);
    wire wr_gap = wr_pend_r && (wr_addr_r == OFS_GAP);
    wire wr_len = wr_pend_r && (wr_addr_r == OFS_FRAME_LEN);

    // ========================================================================
    // software registers
    logic tx_req_r;
    logic rx_en_r;
    logic [7:0] ctl2_r;
    logic [7:0] mac1_r;
    logic [7:0] mac3_r;
    logic phy_dpx_r;
    logic [1:0] flow_r;
    logic [6:0] gap_r;
    logic [10:0] len_r;
    logic [7:0] irq_en_r;
    logic [7:0] irq_flags_r;
    logic aborted_r;
    logic ev_done;
    logic ev_abort;
    logic ev_retry;

    // plain storage registers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rx_en_r <= 1'b0;
            ctl2_r <= RST_CTL_TWO;
            mac1_r <= RST_BYTE;
            mac3_r <= RST_BYTE;
            phy_dpx_r <= 1'b0;
            flow_r <= 2'h0;
            gap_r <= RST_GAP;
            len_r <= RST_FRAME_LEN;
            irq_en_r <= RST_BYTE;
        end else begin
            if (wr_ctl1) rx_en_r <= hwdata_i[CTL1_RX_ENABLE_BIT];
            if (wr_ctl2) ctl2_r <= hwdata_i[7:0];
            if (wr_mac1) mac1_r <= hwdata_i[7:0];
            if (wr_mac3) mac3_r <= hwdata_i[7:0];
            if (wr_phy1) phy_dpx_r <= hwdata_i[PHY1_DPX_BIT];
            if (wr_flow) flow_r <= hwdata_i[1:0];
            if (wr_gap) gap_r <= hwdata_i[6:0];
            if (wr_len) len_r <= hwdata_i[10:0];
            if (wr_ien) irq_en_r <= hwdata_i[7:0];
        end
    end

    // tx request: software sets, hardware clears on done or abort
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_req_r <= 1'b0;
        end else if (wr_ctl1) begin
            tx_req_r <= hwdata_i[CTL1_TXREQ_BIT];
        end else if (ev_done || ev_abort) begin
            tx_req_r <= 1'b0;
        end
    end

    // cleared by a fresh request; a same-cycle abort wins
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            aborted_r <= 1'b0;
        end else if (ev_abort) begin
            aborted_r <= 1'b1;
        end else if (wr_ctl1 && hwdata_i[CTL1_TXREQ_BIT]) begin
            aborted_r <= 1'b0;
        end
    end

    // ========================================================================
    // interrupts: sticky flags, set beats clear
    logic [7:0] irq_set;
    assign irq_set = ({7'h00, ev_abort} << IRQ_TXERR_BIT)
                   | ({7'h00, ev_retry} << IRQ_RETRY_BIT)
                   | ({7'h00, ev_done} << IRQ_TXDONE_BIT);
    wire [7:0] irq_clr = wr_iclr ? hwdata_i[7:0] : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_flags_r <= RST_BYTE;
        end else begin
            irq_flags_r <= (irq_flags_r & ~irq_clr) | irq_set;
        end
    end

    assign irq_o = |(irq_flags_r & irq_en_r);

    // ========================================================================
    // mode decode
    // no negotiation logic exists: duplex comes only from the two select bits
    wire fdx_sel = mac3_r[MAC3_FDX_BIT];
    wire engine_on = ctl2_r[CTL2_ENABLE_BIT];
    wire full_mode = fdx_sel & phy_dpx_r;
    // a mismatch is undefined; it falls back to half so collisions stay handled
    wire half_mode = ~full_mode;
    wire mismatch = fdx_sel ^ phy_dpx_r;
    // only the low flow bit matters with full duplex clear
    wire jam_on = half_mode & ~fdx_sel & flow_r[FLOW_LOW_BIT] & engine_on;
    // collisions do not exist in full duplex
    wire col_hit = half_mode & col_r;
    wire carrier_busy = half_mode & crs_r;

    assign full_duplex_o = full_mode;
    assign rx_enable_o = rx_en_r & engine_on;

    // ========================================================================
    // transmit engine
    macdc_state_t st_r;
    macdc_state_t st_nxt;
    logic [19:0] tmr_r;
    logic [19:0] tmr_nxt;
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic [3:0] att_r;
    logic [3:0] att_nxt;
    logic [15:0] lfsr_r;
    macdc_line_t line_r;
    macdc_line_t line_nxt;

    wire tmr_zero = (tmr_r == 20'h0_0000);
    wire [19:0] gap_cyc = 20'(gap_r * BIT_CYC);
    wire [19:0] byte_reload = 20'(BYTE_CYC - 1);
    // range limit 2^k - 1, k capped at ten as usual for shared media
    wire [3:0] att_inc = att_r + 4'h1;
    wire [3:0] bo_exp = (att_inc > BACKOFF_CAP) ? BACKOFF_CAP : att_inc;
    wire [9:0] bo_mask = ~(10'h3FF << bo_exp);
    wire [9:0] bo_slots = lfsr_r[9:0] & bo_mask;
    wire [19:0] bo_cyc = 20'(bo_slots * SLOT_CYC);
    wire last_byte = (cnt_r + 11'h001) >= len_r;
    wire late = (st_r == ST_DATA) && (cnt_r >= LATE_COL_BYTES);

    // next state and counters
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_zero ? 20'h0_0000 : tmr_r - 20'h0_0001;
        cnt_nxt = cnt_r;
        att_nxt = att_r;
        line_nxt = '0;
        ev_done = 1'b0;
        ev_abort = 1'b0;
        ev_retry = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (tx_req_r && engine_on) begin
                    if (carrier_busy) begin
                        st_nxt = ST_DEFER;
                    end else begin
                        st_nxt = ST_GAP;
                        tmr_nxt = gap_cyc;
                    end
                end else if (jam_on) begin
                    st_nxt = ST_JAM;
                end
            end
            ST_JAM: begin
                line_nxt = '{en: 1'b1, data: PREAMBLE_BYTE};
                if (tx_req_r) begin
                    st_nxt = ST_GAP;
                    tmr_nxt = gap_cyc;
                end else if (!jam_on) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_DEFER: begin
                if (!carrier_busy) begin
                    st_nxt = ST_GAP;
                    tmr_nxt = gap_cyc;
                end
            end
            ST_GAP: begin
                if (tmr_zero) begin
                    st_nxt = ST_PREAMBLE;
                    cnt_nxt = 11'h000;
                    tmr_nxt = byte_reload;
                end
            end
            ST_PREAMBLE, ST_DATA: begin
                if (st_r == ST_PREAMBLE) begin
                    line_nxt = '{en: 1'b1, data: (cnt_r == SFD_INDEX) ? SFD_BYTE : PREAMBLE_BYTE};
                end else begin
                    line_nxt = '{en: 1'b1, data: frame_byte_i};
                end
                if (col_hit) begin
                    if (late || att_r == MAX_RETRIES) begin
                        st_nxt = ST_IDLE;
                        att_nxt = 4'h0;
                        ev_abort = 1'b1;
                    end else begin
                        // request stays set and no error flag rises
                        st_nxt = ST_BACKOFF;
                        att_nxt = att_inc;
                        tmr_nxt = bo_cyc;
                        ev_retry = 1'b1;
                    end
                end else if (tmr_zero) begin
                    tmr_nxt = byte_reload;
                    if (st_r == ST_PREAMBLE && cnt_r == SFD_INDEX) begin
                        st_nxt = ST_DATA;
                        cnt_nxt = 11'h000;
                    end else if (st_r == ST_DATA && last_byte) begin
                        st_nxt = ST_IDLE;
                        att_nxt = 4'h0;
                        ev_done = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 11'h001;
                    end
                end
            end
            ST_BACKOFF: begin
                if (tmr_zero) begin
                    st_nxt = ST_DEFER;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        // disabling the engine drops the medium at once
        if (!engine_on) begin
            st_nxt = ST_IDLE;
            line_nxt = '0;
            att_nxt = 4'h0;
        end
    end

    // engine registers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r <= ST_IDLE;
            tmr_r <= 20'h0_0000;
            cnt_r <= 11'h000;
            att_r <= 4'h0;
            line_r <= '0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            att_r <= att_nxt;
            line_r <= line_nxt;
        end
    end

    // free-running lfsr so retries of two stations drift apart
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lfsr_r <= LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    assign tx_line_o = line_r;
    assign frame_idx_o = cnt_r;

    // ========================================================================
    // read mux
    wire busy = (st_r != ST_IDLE) && (st_r != ST_JAM);
    wire [7:0] ctl1_rd = 8'({6'h00, tx_req_r, rx_en_r} << CTL1_RX_ENABLE_BIT);
    wire [7:0] stat_rd = 8'(({7'h00, busy} << STAT_BUSY_BIT)
                          | ({7'h00, aborted_r} << STAT_ABORT_BIT)
                          | ({7'h00, st_r == ST_JAM} << STAT_JAM_BIT)
                          | ({7'h00, mismatch} << STAT_MISMATCH_BIT));
    wire [31:0] phy1_rd = 32'({31'h0000_0000, phy_dpx_r} << PHY1_DPX_BIT);
    wire [7:0] a = haddr_i[7:0];

    assign rd_mux = (a == OFS_CTL_ONE) ? {24'h00_0000, ctl1_rd}
                  : (a == OFS_CTL_TWO) ? {24'h00_0000, ctl2_r}
                  : (a == OFS_STATUS) ? {24'h00_0000, stat_rd}
                  : (a == OFS_IRQ_FLAGS) ? {24'h00_0000, irq_flags_r}
                  : (a == OFS_IRQ_EN) ? {24'h00_0000, irq_en_r}
                  : (a == OFS_MAC_ONE) ? {24'h00_0000, mac1_r}
                  : (a == OFS_MAC_THREE) ? {24'h00_0000, mac3_r}
                  : (a == OFS_PHY_ONE) ? phy1_rd
                  : (a == OFS_FLOW) ? {30'h0000_0000, flow_r}
                  : (a == OFS_GAP) ? {25'h000_0000, gap_r}
                  : (a == OFS_FRAME_LEN) ? {21'h00_0000, len_r}
                  : (a == OFS_RETRY) ? {28'h000_0000, att_r}
                  : 32'h0000_0000;

endmodule

/* File: bench/macdc_medium.sv */
// far side model: carrier, collision, frame bytes, burst length
`timescale 1ns/1ps
module macdc_medium
    import macdc_pkg::*;
(
    input wire logic clk_i,
    input wire macdc_pkg::macdc_line_t line_i,
    input wire logic [10:0] idx_i,
    input wire logic busy_i,
    input wire logic hit_i,
    output logic crs_o,
    output logic col_o,
    output logic [7:0] byte_o,
    output logic [15:0] run_o
);
    logic [15:0] cnt_r;
    logic en_r;
    // ========================================================================
    // carrier and collision as the bench orders them
    assign crs_o = busy_i;
    assign col_o = hit_i;
    // user buffer stand-in; differs from 55h below index 69h so a stuck preamble shows
    assign byte_o = idx_i[7:0] ^ 8'h3C;
    // last drive burst length, latched as the line drops
    always_ff @(posedge clk_i) begin
        en_r <= line_i.en;
        cnt_r <= line_i.en ? cnt_r + 16'h0001 : 16'h0000;
        if (en_r && !line_i.en) run_o <= cnt_r;
    end
endmodule

/* File: bench/macdc_top_props.sv */
// port-level checks of the duplex, collision and jamming block
`timescale 1ns/1ps
module macdc_top_props
    import macdc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic crs_i,
    input wire logic col_i,
    input wire logic [7:0] frame_byte_i,
    input wire logic [10:0] frame_idx_o,
    input wire macdc_pkg::macdc_line_t tx_line_o,
    input wire logic rx_enable_o,
    input wire logic full_duplex_o,
    input wire logic irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic wr_r, rd_r, mac_r, phy_r, rx_r, ena_r, flow_r;
    logic [7:0] adr_r;
    logic [7:0] ien_r;
    logic [3:0] bc_r;
    logic [3:0] run_r;
    // ========================================================================
    // shadow of software writes; they land at the end of the data phase
    wire take = hsel_i & htrans_i[1] & hready_i;
    wire wr_now = wr_r & hready_i;
    wire fdx_sel = mac_r & phy_r;
    wire rx_sel = rx_r & ena_r;
    wire jam_sel = flow_r & ~mac_r;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            {wr_r, rd_r, mac_r, phy_r, rx_r, flow_r, ien_r} <= 14'h0000;
            ena_r <= RST_CTL_TWO[CTL2_ENABLE_BIT];
        end else begin
            wr_r <= take & hwrite_i;
            rd_r <= take & ~hwrite_i;
            adr_r <= haddr_i[7:0];
            if (wr_now && adr_r == OFS_MAC_THREE) mac_r <= hwdata_i[MAC3_FDX_BIT];
            if (wr_now && adr_r == OFS_PHY_ONE) phy_r <= hwdata_i[PHY1_DPX_BIT];
            if (wr_now && adr_r == OFS_CTL_ONE) rx_r <= hwdata_i[CTL1_RX_ENABLE_BIT];
            if (wr_now && adr_r == OFS_CTL_TWO) ena_r <= hwdata_i[CTL2_ENABLE_BIT];
            if (wr_now && adr_r == OFS_FLOW) flow_r <= hwdata_i[FLOW_LOW_BIT];
            if (wr_now && adr_r == OFS_IRQ_EN) ien_r <= hwdata_i[7:0];
        end
    end
    // byte phase and burst length; a saturating run keeps the compare cheap
    always_ff @(posedge ref_clk_i) begin
        bc_r <= tx_line_o.en ? bc_r + 4'h1 : 4'h0;
        run_r <= !tx_line_o.en ? 4'h0 : (run_r == 4'hF) ? run_r : run_r + 4'h1;
    end
    // ========================================================================
    // assertions
    ready_a: assert property (hreadyout_o && !hresp_o) else $error("bus wait or error seen");
    rdata_idle_a: assert property (!rd_r |-> hrdata_o == 32'h0000_0000)
        else $error("read data outside a read data phase");
    full_dpx_a: assert property (full_duplex_o == fdx_sel)
        else $error("duplex output differs from selects");
    rx_en_a: assert property (rx_enable_o == rx_sel)
        else $error("receive enable differs from settings");
    irq_mask_a: assert property (ien_r == 8'h00 |-> !irq_o)
        else $error("interrupt with every source masked");
    byte_hold_a: assert property (!jam_sel && tx_line_o.en && $past(tx_line_o.en)
        && tx_line_o.data != $past(tx_line_o.data) |-> bc_r == 4'h0)
        else $error("line byte changed inside its 16 cycles");
    col_stop_a: assert property ((!full_duplex_o && !jam_sel && col_i)[*8]
        |=> !tx_line_o.en || run_r < 4'h7) else $error("drive went on through a collision");
    defer_a: assert property ((!full_duplex_o && !jam_sel && crs_i)[*8]
        |-> !$rose(tx_line_o.en)) else $error("drive started over remote carrier");
    reset_out_a: assert property ($fell(sys_rst_i) |-> !tx_line_o.en && !irq_o
        && !full_duplex_o && frame_idx_o == 11'h000) else $error("outputs not idle after reset");
endmodule
bind macdc_top macdc_top_props macdc_top_props_i (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .crs_i(crs_i),
    .col_i(col_i), .frame_byte_i(frame_byte_i), .frame_idx_o(frame_idx_o),
    .tx_line_o(tx_line_o), .rx_enable_o(rx_enable_o), .full_duplex_o(full_duplex_o),
    .irq_o(irq_o));

/* File: bench/macdc_bench.sv */
// self-checking bench over the register bus
`timescale 1ns/1ps
module macdc_bench;
    import macdc_pkg::*;
    localparam int ON = 0;
    localparam int OFF = 1;
    localparam int IRQ = 2;
    localparam int DEEP = 3;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic busy = 1'h0;
    logic hit = 1'h0;
    logic hrdy, hresp, rxe, fdx, irq, crs, col;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [7:0] fbyte;
    logic [10:0] fidx;
    logic [15:0] run;
    macdc_line_t line;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    // ========================================================================
    // clock, design and medium
    always #25 clk = ~clk;
    wire [3:0] st = {fidx >= 11'h042, irq === 1'h1, line.en === 1'h0, line.en === 1'h1};
    macdc_top macdc_top_i (.ref_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
        .crs_i(crs), .col_i(col), .frame_byte_i(fbyte), .frame_idx_o(fidx),
        .tx_line_o(line), .rx_enable_o(rxe), .full_duplex_o(fdx), .irq_o(irq));
    macdc_medium macdc_medium_i (.clk_i(clk), .line_i(line), .idx_i(fidx), .busy_i(busy),
        .hit_i(hit), .crs_o(crs), .col_o(col), .byte_o(fbyte), .run_o(run));
    // ========================================================================
    // bus, compare and wait tasks
    task automatic ck(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // single transfer; read data taken at the data phase edge
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'h1);
        q = hrdata;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        xf(1'h0, a, 32'h0);
        ck(nm, q & m, e);
    endtask
    // bounded wait on st[s]; n keeps the cycles
    task automatic till(input int s, input int lim);
        n = 0;
        while (st[s] !== 1'h1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        ck("wait", 32'(n < lim), 32'h1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog, more than five times the expected run
    initial begin
        #1_250_000;
        mismatches++;
        results();
    end
    // ========================================================================
    // tests
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rc("ctl two", OFS_CTL_TWO, 32'hFFFF_FFFF, 32'h20);
        rc("status", OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
        rc("frame len", OFS_FRAME_LEN, 32'hFFFF_FFFF, 32'h40);
        rc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
        ck("no negotiated fdx", 32'(fdx), 32'h0);
        $display("test reset done");
        xf(1'h1, OFS_GAP, 32'h5);
        xf(1'h1, OFS_FRAME_LEN, 32'h4);
        xf(1'h1, OFS_IRQ_EN, 32'hA);
        xf(1'h1, OFS_MAC_THREE, 32'h1);
        repeat (2) @(posedge clk);
        ck("one select only", 32'(fdx), 32'h0);
        rc("mismatch", OFS_STATUS, 32'h8, 32'h8);
        xf(1'h1, OFS_PHY_ONE, 32'h100);
        repeat (2) @(posedge clk);
        ck("full duplex", 32'(fdx), 32'h1);
        busy <= 1'h1;
        hit <= 1'h1;
        xf(1'h1, OFS_CTL_ONE, 32'hC);
        till(IRQ, 500);
        repeat (4) @(posedge clk);
        ck("rx beside tx", 32'(rxe), 32'h1);
        ck("whole frame", 32'(run == 16'h00C0), 32'h1);
        rc("no retry", OFS_IRQ_FLAGS, 32'hE, 32'h8);
        xf(1'h1, OFS_IRQ_CLR, 32'hFF);
        busy <= 1'h0;
        hit <= 1'h0;
        xf(1'h1, OFS_CTL_ONE, 32'h0);
        ck("irq cleared", 32'(irq), 32'h0);
        xf(1'h1, OFS_MAC_THREE, 32'h0);
        xf(1'h1, OFS_PHY_ONE, 32'h0);
        repeat (2) @(posedge clk);
        ck("half duplex", 32'(fdx), 32'h0);
        $display("test duplex done");
        busy <= 1'h1;
        // filtered carrier lags the pin, so it must stand before the request
        repeat (4) @(posedge clk);
        xf(1'h1, OFS_CTL_ONE, 32'h8);
        repeat (100) @(posedge clk);
        ck("deferred", 32'(line.en), 32'h0);
        rc("request held", OFS_CTL_ONE, 32'h8, 32'h8);
        busy <= 1'h0;
        till(IRQ, 500);
        xf(1'h1, OFS_IRQ_CLR, 32'hFF);
        xf(1'h1, OFS_CTL_ONE, 32'h8);
        till(ON, 100);
        hit <= 1'h1;
        till(OFF, 20);
        hit <= 1'h0;
        rc("request kept", OFS_CTL_ONE, 32'h8, 32'h8);
        rc("retry no error", OFS_IRQ_FLAGS, 32'h6, 32'h4);
        rc("one retry", OFS_RETRY, 32'hFF, 32'h1);
        ck("retry masked", 32'(irq), 32'h0);
        till(IRQ, 1600);
        rc("resent", OFS_IRQ_FLAGS, 32'hA, 32'h8);
        $display("test collision done");
        xf(1'h1, OFS_IRQ_CLR, 32'hFF);
        xf(1'h1, OFS_FRAME_LEN, 32'h46);
        xf(1'h1, OFS_CTL_ONE, 32'h8);
        till(DEEP, 1600);
        hit <= 1'h1;
        repeat (12) @(posedge clk);
        hit <= 1'h0;
        till(IRQ, 20);
        rc("aborted", OFS_STATUS, 32'h2, 32'h2);
        rc("abort flag", OFS_IRQ_FLAGS, 32'hA, 32'h2);
        rc("request cleared", OFS_CTL_ONE, 32'h8, 32'h0);
        repeat (1100) @(posedge clk);
        ck("no resend", 32'(line.en), 32'h0);
        $display("test late collision done");
        xf(1'h1, OFS_IRQ_CLR, 32'hFF);
        xf(1'h1, OFS_FRAME_LEN, 32'h4);
        xf(1'h1, OFS_FLOW, 32'h2);
        repeat (20) @(posedge clk);
        ck("flow x0 off", 32'(line.en), 32'h0);
        xf(1'h1, OFS_FLOW, 32'h3);
        till(ON, 40);
        repeat (4) @(posedge clk);
        ck("jam byte", 32'(line.data), 32'h55);
        rc("jam flag", OFS_STATUS, 32'h4, 32'h4);
        xf(1'h1, OFS_CTL_ONE, 32'h8);
        till(OFF, 40);
        till(ON, 60);
        ck("gap kept", 32'(n >= 10), 32'h1);
        till(IRQ, 500);
        repeat (40) @(posedge clk);
        ck("jam back", 32'({line.en, line.data}), 32'h155);
        xf(1'h1, OFS_FLOW, 32'h0);
        repeat (20) @(posedge clk);
        ck("jam over", 32'(line.en), 32'h0);
        rc("jam flag off", OFS_STATUS, 32'h4, 32'h0);
        $display("test jamming done");
        results();
    end
endmodule
